// [bench/sixio_checker.sv]
// sixio checker: bus answer timing, pin 3 and pull-up relations
// assumes one aclk domain; bound into every sixio_port
`timescale 1ns/1ps
`default_nettype none
module sixio_checker (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    // configuration and pins
    input wire logic master_clear_select,
    input wire logic [5:0] periph_take_over,
    input wire sixio_pkg::sixio_pin_drive_t pin_drive
);
    import sixio_pkg::*;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // both write channels are taken at one edge when both valids are high in the same idle cycle
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write not answered");
    a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read not answered");
    a_rvalid_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arready))
        else $error("read data without request");
    a_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready longer than one cycle");
    // the config register keeps its control at bit 7, so only the port registers drop 7:6
    a_rdata_upper: assert property (($rose(s_axi_rvalid)
        && $past(s_axi_araddr) != {2'b00, SIXIO_ADDR_CONFIG})
        |-> s_axi_rdata[31:6] == 26'h0)
        else $error("unused read bits set");
    a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("read bits above the byte set");
    a_pin3_input: assert property (pin_drive.oe_n[3])
        else $error("pin 3 driven");
    // a taken-over pin is the peripheral's, so its driver is not ours to judge
    a_pull_off_out: assert property ((pin_drive.pull_up & ~pin_drive.oe_n & ~periph_take_over
        & ~$past(periph_take_over)) == 6'h00)
        else $error("pull-up on a driven pin");
    a_pin3_pull: assert property ($stable(master_clear_select) [*3]
        |-> pin_drive.pull_up[3] == master_clear_select)
        else $error("pin 3 pull-up wrong");
endmodule // sixio_checker
bind sixio_port sixio_checker sixio_checker_i (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
    .master_clear_select, .periph_take_over, .pin_drive);
`default_nettype wire

// [bench/sixio_pins_model.sv]
// pin load model: pins follow the port driver, a bench source, pull-ups or noise
// assumes the bench's aclk
`timescale 1ns/1ps
`default_nettype none
module sixio_pins_model (
    // clock
    input wire logic aclk,
    // pin side
    input wire sixio_pkg::sixio_pin_drive_t pin_drive,
    input wire logic [5:0] ext_val,
    input wire logic [5:0] ext_en,
    output logic [5:0] pin_in
);
    import sixio_pkg::*;
    logic [5:0] noise = 6'h15;
    // floating pins toggle so a stale level can never pass for a read
    always_ff @(posedge aclk) noise <= ~noise;
    // port driver wins, then bench source, then weak pull-up
    always_comb
        for (int i = 0; i < 6; i++)
            pin_in[i] = !pin_drive.oe_n[i] ? pin_drive.out[i] :
                ext_en[i] ? ext_val[i] : pin_drive.pull_up[i] ? 1'b1 : noise[i];
endmodule // sixio_pins_model
`default_nettype wire

// [bench/tb.sv]
// tb: register bus master, pin model and reference model for sixio_port
// assumes the package constants and 50 MHz aclk
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sixio_pkg::*;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, arv = 0, mcs = 0;
    logic awrd, wrd, bv, arrd, rv;
    logic [11:0] awa = 0, ara = 0;
    logic [31:0] wd = 0, rdat, v;
    logic [3:0] ws = 0;
    logic [2:0] xm = 0;
    logic [1:0] br, rr, r;
    logic [5:0] ana = 0, pto = 0, po = 0, poe = 6'h3f, ev = 0, een = 6'h3f, pins;
    sixio_pin_drive_t pd;
    int err_count = 0, checks_done = 0, cyc = 0, dir_m = 63, wpu_m = 55, lat_m = 0;
    sixio_port sixio_port_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awrd), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arrd),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
        .master_clear_select(mcs), .crystal_mode_low_power(xm[0]),
        .crystal_mode_medium(xm[1]), .crystal_mode_high_speed(xm[2]), .analog_select(ana),
        .periph_take_over(pto), .periph_out(po), .periph_oe_n(poe), .pin_in(pins),
        .pin_drive(pd));
    sixio_pins_model sixio_pins_model_i (.aclk(aclk), .pin_drive(pd), .ext_val(ev),
        .ext_en(een), .pin_in(pins));
    initial begin
        forever #10 aclk = ~aclk;
    end
    // hang guard
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            test_done;
        end
    end
    task automatic test_done;
        if (err_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            err_count++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask
    // ready is held high, so each wait ends on the answer's own edge
    task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
        awa <= {2'b00, a};
        wd <= d;
        ws <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        do begin
            @(posedge aclk);
            if (awrd) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
        end while (!bv);
        r = br;
    endtask
    task automatic rd(input logic [9:0] a);
        ara <= {2'b00, a};
        arv <= 1'b1;
        do begin
            @(posedge aclk);
            if (arrd) arv <= 1'b0;
        end while (!rv);
        v = rdat;
        r = rr;
    endtask
    task automatic rc(input logic [9:0] a, input logic [31:0] e);
        rd(a);
        chk(v, e);
    endtask
    initial begin
        void'($urandom(28640));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc(SIXIO_ADDR_PIN_DIRECTION, 32'h3f);
        rc(SIXIO_ADDR_PULL_UP_ENABLE, 32'h37);
        rd(10'h3fc);
        chk(r, SIXIO_RESP_SLVERR);
        // data written while pins are inputs must appear once they drive
        for (int k = 0; k < 8; k++) begin
            lat_m = $urandom % 64;
            dir_m = $urandom % 64 | 8;
            ev <= 6'($urandom);
            ana <= k[0] ? 6'($urandom & dir_m) : 6'h00;
            mcs <= k[1];
            wr(SIXIO_ADDR_PORT_PIN_DATA, lat_m, 4'h1);
            chk(r, SIXIO_RESP_OKAY);
            wr(SIXIO_ADDR_PIN_DIRECTION, dir_m, 4'h1);
            repeat (4) @(posedge aclk);
            chk(pd.oe_n, dir_m);
            chk(pd.out & ~pd.oe_n, lat_m & ~dir_m & 63);
            rc(SIXIO_ADDR_PORT_PIN_DATA, ((lat_m & ~dir_m) | (ev & dir_m)) & ~ana
                & ~(mcs ? 8 : 0) & 63);
        end
        wr(SIXIO_ADDR_PORT_PIN_DATA, ~lat_m, 4'h0);
        repeat (2) @(posedge aclk);
        chk(pd.out & ~pd.oe_n, lat_m & ~dir_m & 63);
        for (int m = 0; m < 3; m++) begin
            xm <= 3'b001 << m;
            repeat (2) @(posedge aclk);
            rc(SIXIO_ADDR_PIN_DIRECTION, dir_m | 48);
            rc(SIXIO_ADDR_PULL_UP_ENABLE, (wpu_m & 55) | 48);
        end
        xm <= 3'b000;
        wpu_m = $urandom % 64;
        wr(SIXIO_ADDR_PULL_UP_ENABLE, wpu_m, 4'h1);
        wr(SIXIO_ADDR_PIN_DIRECTION, 63, 4'h1);
        repeat (3) @(posedge aclk);
        chk(pd.pull_up, 8);
        wr(SIXIO_ADDR_CONFIG, 0, 4'h1);
        repeat (3) @(posedge aclk);
        chk(pd.pull_up, (wpu_m & 55) | 8);
        // pulled-up pins left floating must read high
        een <= ~6'(wpu_m & 55);
        repeat (4) @(posedge aclk);
        rc(SIXIO_ADDR_PORT_PIN_DATA, ((wpu_m & 55) | ev) & ~ana
            & ~(mcs ? 8 : 0) & 63);
        wr(SIXIO_ADDR_PIN_DIRECTION, 42, 4'h1);
        repeat (3) @(posedge aclk);
        chk(pd.pull_up, (wpu_m & 34) | 8);
        pto <= 6'h05;
        po <= 6'h04;
        poe <= 6'h3a;
        repeat (3) @(posedge aclk);
        chk(pd.out & 5, 4);
        chk(pd.oe_n & 5, 0);
        // a reset in mid-run returns every pin to input with pull-ups off again, except pin 3's, which follows master_clear_select
        pto <= 6'h00;
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk(pd.oe_n, 63);
        chk(pd.pull_up, 8);
        rc(SIXIO_ADDR_PIN_DIRECTION, 32'h3f);
        rc(SIXIO_ADDR_CONFIG, 32'h80);
        test_done;
    end
endmodule // tb
`default_nettype wire

// [hw/sixio_pkg.sv]
// sixio_pkg: constants, register map and carrier types of the six-pin io port
// assumes a 32-bit axi4-lite register bus; offsets are byte addresses
package sixio_pkg;
    localparam int SIXIO_PINS = 6;
    // printed offsets are not all multiples of four: they are indices, byte address = 4 * index
    localparam logic [7:0] SIXIO_IDX_PORT_PIN_DATA = 8'h05;
    localparam logic [7:0] SIXIO_IDX_PIN_DIRECTION = 8'h85;
    localparam logic [7:0] SIXIO_IDX_PULL_UP_ENABLE = 8'h95;
    localparam logic [7:0] SIXIO_IDX_CONFIG = 8'hc0;
    localparam logic [9:0] SIXIO_ADDR_PORT_PIN_DATA = {SIXIO_IDX_PORT_PIN_DATA, 2'b00};
    localparam logic [9:0] SIXIO_ADDR_PIN_DIRECTION = {SIXIO_IDX_PIN_DIRECTION, 2'b00};
    localparam logic [9:0] SIXIO_ADDR_PULL_UP_ENABLE = {SIXIO_IDX_PULL_UP_ENABLE, 2'b00};
    localparam logic [9:0] SIXIO_ADDR_CONFIG = {SIXIO_IDX_CONFIG, 2'b00};
    // field positions
    localparam int SIXIO_INPUT_ONLY_BIT = 3;
    localparam int SIXIO_CFG_GLOBAL_PULL_UP_BIT = 7;
    // reset values, pin masks and response codes
    localparam logic [5:0] SIXIO_DIR_RESET = 6'h3f;
    localparam logic [5:0] SIXIO_PULL_UP_RESET = 6'h37;
    localparam logic SIXIO_GLOBAL_PULL_UP_RESET = 1'b1; // 1 = pull-ups disabled
    localparam logic [5:0] SIXIO_OSC_PIN_MASK = 6'h30;
    localparam logic [5:0] SIXIO_PULL_UP_IMPL = 6'h37;
    localparam logic [1:0] SIXIO_RESP_OKAY = 2'b00;
    localparam logic [1:0] SIXIO_RESP_SLVERR = 2'b10;

    // pin side carrier
    typedef struct packed {
        logic [5:0] out;
        logic [5:0] oe_n;
        logic [5:0] pull_up;
    } sixio_pin_drive_t;

    // write state machine, one-hot
    typedef enum logic [2:0] {
        SIXIO_W_IDLE = 3'b001,
        SIXIO_W_RESP = 3'b010,
        SIXIO_W_HOLD = 3'b100
    } sixio_wstate_t;
endpackage

// [hw/sixio_port.sv]
// sixio_port: six-pin bidirectional io port with direction, latch and pull-ups
// assumes pins are asynchronous, configuration straps are stable levels from
// the device's fuses, and one axi4-lite master on aclk
// the output latch has no reset: software writes it before it turns a pin to output
// the config register is this block's own home for the global pull-up control
`timescale 1ns/1ps
`default_nettype none
module sixio_port (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // device configuration levels
    input wire logic master_clear_select,
    input wire logic crystal_mode_low_power,
    input wire logic crystal_mode_medium,
    input wire logic crystal_mode_high_speed,
    input wire logic [5:0] analog_select,
    input wire logic [5:0] periph_take_over,
    input wire logic [5:0] periph_out,
    input wire logic [5:0] periph_oe_n,
    // pins
    input wire logic [5:0] pin_in,
    output sixio_pkg::sixio_pin_drive_t pin_drive
);
    import sixio_pkg::*;

    // pin sampling and software-visible registers
    logic [5:0] pin_meta;
    logic [5:0] pin_sync;
    logic [5:0] out_latch;
    logic [5:0] pin_direction;
    logic [5:0] pull_up_enable;
    logic global_pull_up_control;
    logic crystal;
    logic [5:0] pin_read;
    logic [5:0] dir_read;
    logic [5:0] pu_read;

    // write channel state
    sixio_wstate_t wstate;
    logic aw_held;
    logic w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic do_write;

    // read path
    logic [31:0] next_rdata;
    logic next_rresp_err;

    // pin drive selection, one bit per pin
    logic [5:0] next_out;
    logic [5:0] next_oe_n;
    logic [5:0] next_pull_up;

    // register index decode shared by read and write paths
    function automatic logic hit(input logic [11:0] a, input logic [9:0] reg_addr);
        return a[11:10] == 2'b00 && a[9:0] == reg_addr;
    endfunction

    assign crystal = crystal_mode_low_power | crystal_mode_medium | crystal_mode_high_speed;

    // two-flop synchroniser on the asynchronous pins
    // nothing but pin_sync reads pin_meta, which may settle late
    always_ff @(posedge aclk) begin
        pin_meta <= pin_in;
        pin_sync <= pin_meta;
    end

    // readable views of the registers
    always_comb begin
        pin_read = pin_sync;
        pin_read = pin_read & ~analog_select;
        if (master_clear_select) begin
            pin_read[SIXIO_INPUT_ONLY_BIT] = 1'b0;
        end
        dir_read = pin_direction;
        dir_read[SIXIO_INPUT_ONLY_BIT] = 1'b1;
        pu_read = pull_up_enable & SIXIO_PULL_UP_IMPL;
        if (crystal) begin
            dir_read = dir_read | SIXIO_OSC_PIN_MASK;
            pu_read = pu_read | SIXIO_OSC_PIN_MASK;
        end
    end

    // write channel capture: address and data accepted in either order
    // ready is offered only in idle, so the next write waits for the response and a spare cycle
    assign do_write = (wstate == SIXIO_W_IDLE) && aw_held && w_held;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (!aw_held && s_axi_awvalid && wstate == SIXIO_W_IDLE) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (!w_held && s_axi_wvalid && wstate == SIXIO_W_IDLE) begin
                s_axi_wready <= 1'b1;
            end
            if (do_write) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
        end
    end

    // write response sequencing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wstate <= SIXIO_W_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SIXIO_RESP_OKAY;
        end else begin
            case (wstate)
                SIXIO_W_IDLE: begin
                    if (do_write) begin
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= (hit(aw_addr, SIXIO_ADDR_PORT_PIN_DATA)
                            || hit(aw_addr, SIXIO_ADDR_PIN_DIRECTION)
                            || hit(aw_addr, SIXIO_ADDR_PULL_UP_ENABLE)
                            || hit(aw_addr, SIXIO_ADDR_CONFIG)) ? SIXIO_RESP_OKAY
                            : SIXIO_RESP_SLVERR;
                        wstate <= SIXIO_W_RESP;
                    end
                end
                SIXIO_W_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        wstate <= SIXIO_W_HOLD;
                    end
                end
                SIXIO_W_HOLD: wstate <= SIXIO_W_IDLE; // one idle cycle lets ready flags settle
                default: wstate <= SIXIO_W_IDLE;
            endcase
        end
    end

    // output latch: no reset, it powers up unknown
    always_ff @(posedge aclk) begin
        if (do_write && w_strb[0] && hit(aw_addr, SIXIO_ADDR_PORT_PIN_DATA)) begin
            // a bus write covers the whole byte, so every latch bit is addressed and nothing
            // of the sampled pins survives the read-modify-write merge; software that reads
            // first and writes back copies the levels of input pins into the latch
            out_latch <= w_data[5:0];
        end
    end

    // direction register, all inputs after reset
    // bit 3 is stored as 1, so the input-only pin can never become an output
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_direction <= SIXIO_DIR_RESET;
        end else if (do_write && w_strb[0] && hit(aw_addr, SIXIO_ADDR_PIN_DIRECTION)) begin
            pin_direction <= w_data[5:0] | 6'h08;
        end
    end

    // pull-up enables and the global control held in the config register
    // the global control is 1 after reset, so a powered-up port loads no pin but pin 3, whose pull-up follows master_clear_select
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pull_up_enable <= SIXIO_PULL_UP_RESET;
            global_pull_up_control <= SIXIO_GLOBAL_PULL_UP_RESET;
        end else if (do_write && w_strb[0]) begin
            if (hit(aw_addr, SIXIO_ADDR_PULL_UP_ENABLE)) begin
                pull_up_enable <= w_data[5:0] & SIXIO_PULL_UP_IMPL;
            end
            if (hit(aw_addr, SIXIO_ADDR_CONFIG)) begin
                global_pull_up_control <= w_data[SIXIO_CFG_GLOBAL_PULL_UP_BIT];
            end
        end
    end

    // per-pin drive selection: pin 3 never drives, a taken-over pin follows its peripheral
    genvar g;
    generate
        for (g = 0; g < SIXIO_PINS; g++) begin : g_pin
            if (g == SIXIO_INPUT_ONLY_BIT) begin : g_input_only
                assign next_out[g] = 1'b0;
                assign next_oe_n[g] = 1'b1;
                assign next_pull_up[g] = master_clear_select;
            end else begin : g_io
                // direction acts even on analog pins; software keeps them inputs
                assign next_out[g] = periph_take_over[g] ? periph_out[g]
                    : out_latch[g];
                assign next_oe_n[g] = periph_take_over[g] ? periph_oe_n[g]
                    : pin_direction[g];
                // pull-up dropped on outputs and while the peripheral owns the pin
                assign next_pull_up[g] = ~periph_take_over[g] & pull_up_enable[g]
                    & pin_direction[g] & ~global_pull_up_control;
            end
        end
    endgenerate

    // pin drivers registered so outputs come straight from flops; one process owns the port
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_drive.out <= 6'h00;
            pin_drive.oe_n <= SIXIO_DIR_RESET;
            pin_drive.pull_up <= 6'h00;
        end else begin
            pin_drive.out <= next_out;
            pin_drive.oe_n <= next_oe_n;
            pin_drive.pull_up <= next_pull_up;
        end
    end

    // read data mux; upper bits stay zero
    // the config register reads back only the global pull-up control at bit 7
    always_comb begin
        next_rdata = 32'h00000000;
        next_rresp_err = 1'b0;
        if (hit(s_axi_araddr, SIXIO_ADDR_PORT_PIN_DATA)) begin
            next_rdata[5:0] = pin_read;
        end else if (hit(s_axi_araddr, SIXIO_ADDR_PIN_DIRECTION)) begin
            next_rdata[5:0] = dir_read;
        end else if (hit(s_axi_araddr, SIXIO_ADDR_PULL_UP_ENABLE)) begin
            next_rdata[5:0] = pu_read;
        end else if (hit(s_axi_araddr, SIXIO_ADDR_CONFIG)) begin
            next_rdata[SIXIO_CFG_GLOBAL_PULL_UP_BIT] = global_pull_up_control;
        end else begin
            next_rresp_err = 1'b1;
        end
    end

    // read channel: address taken one cycle, data presented the next
    // read data is captured at the address handshake; a later pin change shows next time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= SIXIO_RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= next_rresp_err ? SIXIO_RESP_SLVERR : SIXIO_RESP_OKAY;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (!s_axi_rvalid && !s_axi_arready && s_axi_arvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule // sixio_port
`default_nettype wire
